// ===== core/acc_pkg.sv
// Constants for the converter control block: register offsets, field positions,
// reset values and sequencing counts. Assumes a byte-wide register port.
package acc_pkg;

  localparam int ACC_ADDR_W = 5;
  localparam int ACC_DATA_W = 8;

  // Register offsets (byte addresses)
  localparam logic [4:0] OFS_MAIN_CTRL    = 5'h00;
  localparam logic [4:0] OFS_ACCUM_CTRL   = 5'h01;
  localparam logic [4:0] OFS_CLOCK_REF    = 5'h02;
  localparam logic [4:0] OFS_DELAY_CTRL   = 5'h03;
  localparam logic [4:0] OFS_WINDOW_MODE  = 5'h04;
  localparam logic [4:0] OFS_SAMPLE_LEN   = 5'h05;
  localparam logic [4:0] OFS_INPUT_SEL    = 5'h06;
  localparam logic [4:0] OFS_COMMAND      = 5'h08;
  localparam logic [4:0] OFS_EVENT_CTRL   = 5'h09;
  localparam logic [4:0] OFS_IRQ_ENABLE   = 5'h0A;
  localparam logic [4:0] OFS_FLAGS        = 5'h0B;
  localparam logic [4:0] OFS_RESULT_LO    = 5'h10;
  localparam logic [4:0] OFS_RESULT_HI    = 5'h11;
  localparam logic [4:0] OFS_WIN_LOW_LO   = 5'h12;
  localparam logic [4:0] OFS_WIN_LOW_HI   = 5'h13;
  localparam logic [4:0] OFS_WIN_HIGH_LO  = 5'h14;
  localparam logic [4:0] OFS_WIN_HIGH_HI  = 5'h15;

  // Field positions
  localparam int MAIN_ENABLE_BIT   = 0;
  localparam int MAIN_FREE_RUNNING_BIT  = 1;
  localparam int MAIN_RES8_BIT     = 2;
  localparam int REF_LSB           = 4;
  localparam int DELAY_INIT_LSB    = 5;
  localparam int DELAY_AUTO_BIT    = 4;
  localparam int IRQ_RESULT_BIT    = 0;
  localparam int IRQ_WINDOW_BIT    = 1;

  // Reset value shared by every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Encodings
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_SUPPLY   = 2'h1;
  localparam logic [2:0] WIN_NONE     = 3'h0;
  localparam logic [2:0] WIN_BELOW    = 3'h1;
  localparam logic [2:0] WIN_ABOVE    = 3'h2;
  localparam logic [2:0] WIN_INSIDE   = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE  = 3'h4;
  localparam logic [2:0] INIT_MAX_CODE = 3'h5;
  localparam logic [2:0] ACCUM_MAX_CODE = 3'h6;

  // Sequencing counts in converter clock cycles
  localparam logic [8:0] INIT_STEP_CYCLES   = 9'h010;
  localparam logic [5:0] SAMPLE_BASE_CYCLES = 6'h02;

  typedef enum logic [2:0] {ACC_IDLE, ACC_INIT, ACC_SAMPLE, ACC_CONVERT, ACC_DELAY} acc_state_e;

endpackage

// ===== core/acc_top.sv
// Converter control block: register file, clock prescaler, start/abort sequencing,
// accumulation and window comparison for a successive-approximation core.
// Assumes the analog core, event and wake inputs run on clk.
//
// Contract
// R1: reference field: 0 picks internal reference, 1 picks supply; others reserved.
// R2: converter clock is peripheral clock divided by 2 to 256 per code.
// R3: startup delay of 0,16,32,64,128,256 converter cycles before first sample.
// R4: the same startup delay applies after deep sleep wake for a measurement.
// R5: auto delay variation increments sampling delay after each sample, wrapping.
// R6: wait sampling-delay converter cycles between samples with capacitor open.
// R7: sampling lasts two converter cycles plus the sample-length extension.
// R8: window mode: none, below, above, inside, outside; others reserved.
// R9: window compare uses full 16-bit result with strict inequalities.
// R10: input codes 0-11 pins, 1C converter, 1D reference, 1E temperature, 1F ground.
// R11: channel change during conversion takes effect only after it completes.
// R12: writing one to start bit begins one measurement or first free-run one.
// R13: start bit reads one while converting and clears on completion.
// R14: writing zero to start bit during conversion aborts it.
// R15: with event start enabled, an event starts a conversion.
// R16: interrupt enable bit 1 gates window request, bit 0 result request.
// R17: result flag sets on completion; cleared by writing one or reading result.
// R18: window flag set at end of conversion on match; same clearing.
// R19: with accumulation, thresholds compare against the accumulated total only.
// R20: free running starts a new conversion right after one completes.
// R21: prescaler and counters run on clk, step on converter tick, reset when disabled.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module acc_top
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [acc_pkg::ACC_ADDR_W-1:0] reg_addr,
  input  wire logic [acc_pkg::ACC_DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [acc_pkg::ACC_DATA_W-1:0] reg_rdata,
  input  wire logic                    event_trigger,
  input  wire logic                    deep_sleep_wake,
  input  wire logic                    core_done,
  input  wire logic [9:0]              core_data,
  output logic                         adc_clk,
  output logic      [1:0]              ref_sel,
  output logic      [4:0]              channel_sel,
  output logic                         cap_open,
  output logic                         core_start,
  output logic                         irq_result,
  output logic                         irq_window
);
  import acc_pkg::*;

  // Software fields
  logic        enable, free_running, res8, auto_delay_variation, event_start_enable;
  logic [2:0]  accum_sel, clock_divider_sel, startup_delay_sel, window_compare_mode;
  logic [1:0]  reference_choice;
  logic [3:0]  inter_sample_delay;
  logic [4:0]  sampling_extension, input_channel;
  logic [1:0]  irq_enable;
  logic [15:0] window_low_threshold, window_high_threshold;

  // Block state
  logic        result_ready, window_match, init_pending;
  logic [15:0] conversion_result, acc_sum;
  acc_state_e  state;
  logic [8:0]  seq_cnt;
  logic [6:0]  smp_cnt;
  logic [7:0]  clock_divider_sel_cnt;

  // Decoded strobes and combinational helpers
  logic        adc_tick, last_sample, conv_done, busy, start_req;
  logic        abort_req, win_hit, result_read, flag_wr;
  logic [7:0]  clock_divider_sel_mask;
  logic [8:0]  init_cycles;
  logic [5:0]  sample_cycles;
  logic [6:0]  samples_total;
  logic [15:0] sample_value, next_sum;

  function automatic logic wr_at(input logic [4:0] ofs);
    wr_at = reg_wr && (reg_addr == ofs);
  endfunction

  // Prescaler: tick every 2^(code+1) peripheral clocks
  always_comb begin
    clock_divider_sel_mask = 8'((16'h0002 << clock_divider_sel) - 16'h0001);  // R2
    adc_tick   = enable && ((clock_divider_sel_cnt & clock_divider_sel_mask) == clock_divider_sel_mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_divider_sel_cnt <= 8'h00;
      adc_clk   <= 1'b0;
    end else if (!enable) begin
      clock_divider_sel_cnt <= 8'h00;  // R21
      adc_clk   <= 1'b0;
    end else begin
      clock_divider_sel_cnt <= clock_divider_sel_cnt + 8'h01;  // R21
      adc_clk   <= ((clock_divider_sel_cnt + 8'h01) & clock_divider_sel_mask) > (clock_divider_sel_mask >> 1);  // R2
    end
  end

  // Sequencing lengths
  always_comb begin
    if (startup_delay_sel == 3'h0 || startup_delay_sel > INIT_MAX_CODE) begin
      init_cycles = 9'h000;  // R3
    end else begin
      init_cycles = 9'(INIT_STEP_CYCLES << (startup_delay_sel - 3'h1));  // R3
    end
    sample_cycles = SAMPLE_BASE_CYCLES + {1'b0, sampling_extension};  // R7
    samples_total = 7'(8'h01 << ((accum_sel > ACCUM_MAX_CODE) ? ACCUM_MAX_CODE : accum_sel));
    sample_value  = res8 ? {8'h00, core_data[9:2]} : {6'h00, core_data};
    next_sum      = acc_sum + sample_value;
    last_sample   = (smp_cnt == samples_total - 7'h01);
    conv_done     = (state == ACC_CONVERT) && core_done && last_sample;
  end

  // Window comparison on the accumulated total only
  always_comb begin
    unique case (window_compare_mode)  // R8
      WIN_BELOW:   win_hit = next_sum < window_low_threshold;  // R9 R19
      WIN_ABOVE:   win_hit = next_sum > window_high_threshold;  // R9
      WIN_INSIDE:  win_hit = (next_sum > window_low_threshold) && (next_sum < window_high_threshold);
      WIN_OUTSIDE: win_hit = (next_sum < window_low_threshold) || (next_sum > window_high_threshold);
      default:     win_hit = 1'b0;
    endcase
  end

  always_comb begin
    busy        = (state != ACC_IDLE);
    start_req   = enable && !busy && ((wr_at(OFS_COMMAND) && reg_wdata[0])
                  || (event_start_enable && event_trigger));  // R12 R15
    abort_req   = busy && wr_at(OFS_COMMAND) && !reg_wdata[0];  // R14
    result_read = reg_rd && (reg_addr == OFS_RESULT_LO || reg_addr == OFS_RESULT_HI);
    flag_wr     = wr_at(OFS_FLAGS);
  end

  // Plain control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {res8, free_running, enable} <= 3'h0;
      accum_sel             <= REG_RESET[2:0];
      reference_choice      <= REF_INTERNAL;
      clock_divider_sel     <= REG_RESET[2:0];
      startup_delay_sel     <= REG_RESET[2:0];
      auto_delay_variation  <= 1'b0;
      window_compare_mode   <= WIN_NONE;
      sampling_extension    <= REG_RESET[4:0];
      input_channel         <= REG_RESET[4:0];
      event_start_enable    <= 1'b0;
      irq_enable            <= REG_RESET[1:0];
      window_low_threshold  <= 16'h0000;
      window_high_threshold <= 16'h0000;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_MAIN_CTRL: begin
          enable       <= reg_wdata[MAIN_ENABLE_BIT];
          free_running <= reg_wdata[MAIN_FREE_RUNNING_BIT];
          res8         <= reg_wdata[MAIN_RES8_BIT];
        end
        OFS_ACCUM_CTRL:  accum_sel <= reg_wdata[2:0];
        OFS_CLOCK_REF: begin
          reference_choice  <= reg_wdata[REF_LSB +: 2];  // R1
          clock_divider_sel <= reg_wdata[2:0];
        end
        OFS_DELAY_CTRL: begin
          startup_delay_sel    <= reg_wdata[DELAY_INIT_LSB +: 3];
          auto_delay_variation <= reg_wdata[DELAY_AUTO_BIT];
        end
        OFS_WINDOW_MODE: window_compare_mode <= reg_wdata[2:0];
        OFS_SAMPLE_LEN:  sampling_extension  <= reg_wdata[4:0];
        OFS_INPUT_SEL:   input_channel       <= reg_wdata[4:0];  // R10
        OFS_EVENT_CTRL:  event_start_enable  <= reg_wdata[0];
        OFS_IRQ_ENABLE:  irq_enable          <= reg_wdata[1:0];  // R16
        OFS_WIN_LOW_LO:  window_low_threshold[7:0]   <= reg_wdata;
        OFS_WIN_LOW_HI:  window_low_threshold[15:8]  <= reg_wdata;
        OFS_WIN_HIGH_LO: window_high_threshold[7:0]  <= reg_wdata;
        OFS_WIN_HIGH_HI: window_high_threshold[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Sampling delay: software write wins over the automatic step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inter_sample_delay <= REG_RESET[3:0];
    end else if (wr_at(OFS_DELAY_CTRL)) begin
      inter_sample_delay <= reg_wdata[3:0];
    end else if (auto_delay_variation && state == ACC_CONVERT && core_done) begin
      inter_sample_delay <= inter_sample_delay + 4'h1;  // R5
    end
  end

  // Startup delay owed on enable, switch to internal reference, or deep sleep wake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_pending <= 1'b0;
    end else if ((wr_at(OFS_MAIN_CTRL) && reg_wdata[MAIN_ENABLE_BIT] && !enable)
                 || (wr_at(OFS_CLOCK_REF) && reg_wdata[REF_LSB +: 2] == REF_INTERNAL
                     && reference_choice != REF_INTERNAL)) begin
      init_pending <= 1'b1;  // R3
    end else if (deep_sleep_wake) begin
      init_pending <= 1'b1;  // R4
    end else if (state == ACC_INIT && adc_tick && seq_cnt == init_cycles - 9'h001) begin
      init_pending <= 1'b0;
    end else if (start_req && init_cycles == 9'h000) begin
      init_pending <= 1'b0;
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= ACC_IDLE;
      seq_cnt     <= 9'h000;
      smp_cnt     <= 7'h00;
      acc_sum     <= 16'h0000;
      channel_sel <= 5'h00;
      core_start  <= 1'b0;
    end else begin
      core_start <= 1'b0;
      if (!enable || abort_req) begin
        state   <= ACC_IDLE;  // R14 R21
        seq_cnt <= 9'h000;
      end else begin
        unique case (state)
          ACC_IDLE: begin
            if (start_req) begin
              channel_sel <= input_channel;  // R11
              acc_sum     <= 16'h0000;
              smp_cnt     <= 7'h00;
              seq_cnt     <= 9'h000;
              state       <= (init_pending && init_cycles != 9'h000) ? ACC_INIT : ACC_SAMPLE;  // R3 R4
            end
          end
          ACC_INIT: begin
            if (adc_tick) begin
              seq_cnt <= seq_cnt + 9'h001;
              if (seq_cnt == init_cycles - 9'h001) begin
                seq_cnt <= 9'h000;
                state   <= ACC_SAMPLE;
              end
            end
          end
          ACC_SAMPLE: begin
            if (adc_tick) begin
              seq_cnt <= seq_cnt + 9'h001;
              if (seq_cnt == {3'h0, sample_cycles} - 9'h001) begin  // R7
                seq_cnt    <= 9'h000;
                core_start <= 1'b1;
                state      <= ACC_CONVERT;
              end
            end
          end
          ACC_CONVERT: begin
            if (core_done) begin
              acc_sum <= next_sum;
              smp_cnt <= smp_cnt + 7'h01;
              seq_cnt <= 9'h000;
              if (last_sample) begin
                if (free_running) begin
                  channel_sel <= input_channel;  // R11 R20
                  acc_sum     <= 16'h0000;
                  smp_cnt     <= 7'h00;
                  state       <= ACC_SAMPLE;  // R20
                end else begin
                  state <= ACC_IDLE;  // R13
                end
              end else if (inter_sample_delay == 4'h0 && !auto_delay_variation) begin
                state <= ACC_SAMPLE;
              end else begin
                state <= ACC_DELAY;  // R6
              end
            end
          end
          ACC_DELAY: begin
            if (inter_sample_delay == 4'h0) begin
              state <= ACC_SAMPLE;
            end else if (adc_tick) begin
              seq_cnt <= seq_cnt + 9'h001;
              if (seq_cnt == {5'h00, inter_sample_delay} - 9'h001) begin  // R6
                seq_cnt <= 9'h000;
                state   <= ACC_SAMPLE;
              end
            end
          end
          default: state <= ACC_IDLE;
        endcase
      end
    end
  end

  // Capacitor stays open while sampling and during the inter-sample wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_open <= 1'b0;
    end else begin
      cap_open <= enable && (state == ACC_SAMPLE || state == ACC_DELAY);  // R6
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_sel <= REF_INTERNAL;
    end else begin
      ref_sel <= reference_choice;  // R1
    end
  end

  // Result and flags; a completion in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conversion_result <= 16'h0000;
      result_ready      <= 1'b0;
      window_match      <= 1'b0;
    end else begin
      if (conv_done) begin
        conversion_result <= next_sum;
      end
      result_ready <= conv_done
                      || (result_ready && !result_read && !(flag_wr && reg_wdata[IRQ_RESULT_BIT]));  // R17
      window_match <= (conv_done && win_hit)
                      || (window_match && !result_read && !(flag_wr && reg_wdata[IRQ_WINDOW_BIT]));  // R18
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_result <= 1'b0;
      irq_window <= 1'b0;
    end else begin
      irq_result <= result_ready && irq_enable[IRQ_RESULT_BIT];  // R16
      irq_window <= window_match && irq_enable[IRQ_WINDOW_BIT];  // R16
    end
  end

  // Read port: data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        OFS_MAIN_CTRL:   reg_rdata <= {5'h00, res8, free_running, enable};
        OFS_ACCUM_CTRL:  reg_rdata <= {5'h00, accum_sel};
        OFS_CLOCK_REF:   reg_rdata <= {2'h0, reference_choice, 1'b0, clock_divider_sel};
        OFS_DELAY_CTRL:  reg_rdata <= {startup_delay_sel, auto_delay_variation, inter_sample_delay};
        OFS_WINDOW_MODE: reg_rdata <= {5'h00, window_compare_mode};
        OFS_SAMPLE_LEN:  reg_rdata <= {3'h0, sampling_extension};
        OFS_INPUT_SEL:   reg_rdata <= {3'h0, input_channel};
        OFS_COMMAND:     reg_rdata <= {7'h00, busy};  // R13
        OFS_EVENT_CTRL:  reg_rdata <= {7'h00, event_start_enable};
        OFS_IRQ_ENABLE:  reg_rdata <= {6'h00, irq_enable};
        OFS_FLAGS:       reg_rdata <= {6'h00, window_match, result_ready};
        OFS_RESULT_LO:   reg_rdata <= conversion_result[7:0];
        OFS_RESULT_HI:   reg_rdata <= conversion_result[15:8];
        OFS_WIN_LOW_LO:  reg_rdata <= window_low_threshold[7:0];
        OFS_WIN_LOW_HI:  reg_rdata <= window_low_threshold[15:8];
        OFS_WIN_HIGH_LO: reg_rdata <= window_high_threshold[7:0];
        OFS_WIN_HIGH_HI: reg_rdata <= window_high_threshold[15:8];
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // acc_top

// ===== testbench/acc_top_asserts.sv
// Port-level timing checker for the converter control block.
// Assumes one clock clk and the asynchronous active-high reset rst.
`timescale 1ns/1ps
module acc_top_asserts
  import acc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       core_done,
  input wire logic [1:0] ref_sel,
  input wire logic [4:0] channel_sel,
  input wire logic       cap_open,
  input wire logic       core_start,
  input wire logic       irq_result,
  input wire logic       irq_window
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  start_pulse_a: assert property (core_start |=> !core_start)
    else $error("core_start wider than one cycle");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its answer cycle");
  chan_hold_a: assert property ((core_done || core_start) |-> $stable(channel_sel))
    else $error("channel changed inside a conversion");
  cap_start_a: assert property (core_start |-> cap_open)
    else $error("core_start without sampling phase");
  sample_min_a: assert property ($rose(cap_open) |-> !core_start ##1 !core_start)
    else $error("sampling phase shorter than two ticks");
  irq_rise_a: assert property ($rose(irq_result) |-> $past(core_done, 2)
    || ($past(reg_wr, 2) && $past(reg_addr, 2) == OFS_IRQ_ENABLE))
    else $error("result request rose without cause");
  win_rise_a: assert property ($rose(irq_window) |-> $past(core_done, 2)
    || ($past(reg_wr, 2) && $past(reg_addr, 2) == OFS_IRQ_ENABLE))
    else $error("window request rose without cause");
  irq_fall_a: assert property ($fell(irq_result) |-> $past(reg_wr, 2) || $past(reg_rd, 2))
    else $error("result request fell without access");
  ref_follow_a: assert property (reg_wr && reg_addr == OFS_CLOCK_REF
    |-> ##2 ref_sel == $past(reg_wdata[5:4], 2))
    else $error("reference output not following register");
endmodule // acc_top_asserts

bind acc_top acc_top_asserts u_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .core_done, .ref_sel, .channel_sel, .cap_open, .core_start, .irq_result, .irq_window);

// ===== testbench/acc_core_model.sv
// Behavioural analog core: answers each core_start after LAT clocks.
// Sample value is the latched channel with a fixed low pattern; data toggles when not valid.
`timescale 1ns/1ps
module acc_core_model #(
  parameter int LAT = 6
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       core_start,
  input  wire logic [4:0] channel_sel,
  output logic            core_done,
  output logic      [9:0] core_data
);
  int         cnt;
  logic [4:0] chan;
  // Keeps converting after an abort, like a real core that was not told
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt       <= 0;
      chan      <= 5'h00;
      core_done <= 1'b0;
      core_data <= 10'h000;
    end else begin
      core_done <= 1'b0;
      core_data <= ~core_data;
      if (core_start) begin
        cnt  <= LAT;
        chan <= channel_sel;
      end else if (cnt == 1) begin
        cnt       <= 0;
        core_done <= 1'b1;
        core_data <= {chan, 5'h0A};
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // acc_core_model

// ===== testbench/acc_top_tb.sv
// Scenario testbench for the converter control block over the byte register port.
// Assumes the core model answers each core_start after a fixed latency.
`timescale 1ns/1ps
module acc_top_tb;
  import acc_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       event_trigger = 1'b0, deep_sleep_wake = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [9:0] core_data;
  logic [4:0] channel_sel;
  logic [1:0] ref_sel;
  logic       adc_clk, cap_open, core_start, core_done, irq_result, irq_window;
  int         error_cnt = 0, check_count = 0, starts = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) if (core_start === 1'b1) starts++;

  acc_top u_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .event_trigger,
    .deep_sleep_wake, .core_done, .core_data, .adc_clk, .ref_sel, .channel_sel, .cap_open,
    .core_start, .irq_result, .irq_window);
  acc_core_model u_core (.clk, .rst, .core_start, .channel_sel, .core_done, .core_data);

  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] e, input string s);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(s, e, reg_rdata);
  endtask
  task automatic evt(input bit w);
    @(posedge clk);
    if (w) deep_sleep_wake <= 1'b1;
    else event_trigger <= 1'b1;
    @(posedge clk);
    deep_sleep_wake <= 1'b0;
    event_trigger   <= 1'b0;
  endtask
  // Counts edges until core_start (w=0) or core_done (w=1) is seen
  task automatic till(input bit w, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((w ? core_done : core_start) !== 1'b1 && n < 3000);
  endtask
  task automatic run(input int s, output int n);
    int k;
    wr(OFS_COMMAND, 8'h01);
    till(0, n);
    till(1, k);
    repeat (s - 1) begin
      till(0, k);
      till(1, k);
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_regs;
    logic [4:0] a [7] = '{OFS_DELAY_CTRL, OFS_WINDOW_MODE, OFS_SAMPLE_LEN, OFS_INPUT_SEL,
                          OFS_COMMAND, OFS_EVENT_CTRL, OFS_IRQ_ENABLE};
    logic [7:0] v [7] = '{8'hFF, 8'h04, 8'h1F, 8'h1F, 8'h00, 8'h01, 8'h03};
    for (int i = 0; i < 7; i++) begin
      rc(a[i], REG_RESET, "reset value");
      wr(a[i], v[i]);
      rc(a[i], v[i], "read back");
      wr(a[i], 8'h00);
    end
    wr(5'h07, 8'h5A);
    rc(5'h07, 8'h00, "unmapped");
    chk("adc_clk idle", 0, adc_clk);
    $display("t_regs done");
  endtask
  task automatic t_timing;
    int n;
    wr(OFS_DELAY_CTRL, 8'h20);
    wr(OFS_CLOCK_REF, 8'h11);
    wr(OFS_SAMPLE_LEN, 8'h03);
    wr(OFS_IRQ_ENABLE, 8'h01);
    wr(OFS_MAIN_CTRL, 8'h01);
    chk("ref_sel", REF_SUPPLY, ref_sel);
    run(1, n);
    chk("first start delay", 1, n >= 80 && n <= 87);
    rc(OFS_COMMAND, 8'h00, "busy clear");
    chk("irq_result", 1, irq_result);
    rc(OFS_FLAGS, 8'h01, "flags set");
    rc(OFS_RESULT_LO, 8'h0A, "result");
    rc(OFS_FLAGS, 8'h00, "flags cleared");
    chk("irq_result cleared", 0, irq_result);
    run(1, n);
    chk("plain start delay", 1, n >= 16 && n <= 23);
    rc(OFS_RESULT_LO, 8'h0A, "result");
    evt(1);
    run(1, n);
    chk("wake start delay", 1, n >= 80 && n <= 87);
    rc(OFS_RESULT_LO, 8'h0A, "result");
    wr(OFS_DELAY_CTRL, 8'h00);
    wr(OFS_SAMPLE_LEN, 8'h00);
    wr(OFS_CLOCK_REF, 8'h00);
    $display("t_timing done");
  endtask
  task automatic t_abort;
    int s0;
    // Long sampling so the abort lands well before core_start
    wr(OFS_SAMPLE_LEN, 8'h1F);
    s0 = starts;
    wr(OFS_COMMAND, 8'h01);
    rc(OFS_COMMAND, 8'h01, "busy");
    wr(OFS_COMMAND, 8'h00);
    rc(OFS_COMMAND, 8'h00, "aborted");
    repeat (120) @(posedge clk);
    chk("no core start", s0, starts);
    rc(OFS_FLAGS, 8'h00, "no flags");
    wr(OFS_SAMPLE_LEN, 8'h00);
    $display("t_abort done");
  endtask
  task automatic t_event;
    int s0, n;
    s0 = starts;
    evt(0);
    repeat (30) @(posedge clk);
    chk("event ignored", s0, starts);
    wr(OFS_EVENT_CTRL, 8'h01);
    evt(0);
    rc(OFS_COMMAND, 8'h01, "event busy");
    till(1, n);
    repeat (2) @(posedge clk);
    rc(OFS_FLAGS, 8'h01, "event result");
    rc(OFS_RESULT_LO, 8'h0A, "result");
    wr(OFS_EVENT_CTRL, 8'h00);
    // Free run must restart sampling right after completion
    wr(OFS_MAIN_CTRL, 8'h03);
    run(1, n);
    till(0, n);
    chk("free run restart", 1, n <= 4);
    wr(OFS_COMMAND, 8'h00);
    wr(OFS_MAIN_CTRL, 8'h01);
    $display("t_event done");
  endtask
  task automatic t_channel;
    int n;
    wr(OFS_INPUT_SEL, 8'h05);
    wr(OFS_COMMAND, 8'h01);
    wr(OFS_INPUT_SEL, 8'h1C);
    till(1, n);
    chk("channel held", 5'h05, channel_sel);
    repeat (2) @(posedge clk);
    rc(OFS_RESULT_LO, 8'hAA, "old channel result");
    run(1, n);
    chk("channel new", 5'h1C, channel_sel);
    rc(OFS_RESULT_HI, 8'h03, "new channel result");
    $display("t_channel done");
  endtask
  task automatic t_window;
    logic [4:0]  ch [4] = '{5'h00, 5'h05, 5'h0B, 5'h1F};
    logic [15:0] r, lo, hi;
    logic        mt;
    int          n;
    lo = 16'h00AA;
    hi = 16'h03EA;
    wr(OFS_WIN_LOW_LO, lo[7:0]);
    wr(OFS_WIN_LOW_HI, lo[15:8]);
    wr(OFS_WIN_HIGH_LO, hi[7:0]);
    wr(OFS_WIN_HIGH_HI, hi[15:8]);
    wr(OFS_IRQ_ENABLE, 8'h03);
    for (int c = 0; c < 4; c++) begin
      r = {6'h00, ch[c], 5'h0A};
      wr(OFS_INPUT_SEL, {3'h0, ch[c]});
      for (int m = 0; m < 6; m++) begin
        mt = (m == 1 && r < lo) || (m == 2 && r > hi) || (m == 3 && r > lo && r < hi)
          || (m == 4 && (r < lo || r > hi));
        wr(OFS_WINDOW_MODE, 8'(m));
        run(1, n);
        chk("irq_window", mt, irq_window);
        rc(OFS_FLAGS, {6'h00, mt, 1'b1}, "window flags");
        rc(OFS_RESULT_LO, r[7:0], "result");
      end
    end
    wr(OFS_WINDOW_MODE, 8'h00);
    $display("t_window done");
  endtask
  task automatic t_delay;
    int n;
    wr(OFS_ACCUM_CTRL, 8'h01);
    wr(OFS_DELAY_CTRL, 8'h08);
    wr(OFS_INPUT_SEL, 8'h05);
    wr(OFS_COMMAND, 8'h01);
    till(0, n);
    till(1, n);
    repeat (8) @(posedge clk);
    #1 chk("cap open in delay", 1, cap_open);
    till(0, n);
    chk("inter-sample gap", 1, n >= 10 && n <= 16);
    till(1, n);
    repeat (2) @(posedge clk);
    rc(OFS_RESULT_LO, 8'h54, "accumulated");
    wr(OFS_DELAY_CTRL, 8'h1F);
    run(2, n);
    rc(OFS_DELAY_CTRL, 8'h11, "auto delay wrap");
    rc(OFS_RESULT_HI, 8'h01, "accumulated");
    $display("t_delay done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_timing;
    t_abort;
    t_event;
    t_channel;
    t_window;
    t_delay;
    stop_test;
  end
  initial begin
    #200000;
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    stop_test;
  end
endmodule // acc_top_tb
